/* File: rtl/src1_decode_pkg.sv */
// constants and types for the second-source doubleword decoder
package src1_decode_pkg;
	// field positions within the doubleword
	localparam int RSV_HI = 31;
	localparam int RSV_LO = 25;
	localparam int VS_HI = 24;
	localparam int VS_LO = 21;
	localparam int RSV20_BIT = 20;
	localparam int RW_HI = 20;
	localparam int RW_LO = 18;
	localparam int CS_HI = 19;
	localparam int CS_LO = 16;
	localparam int HS_HI = 17;
	localparam int HS_LO = 16;
	localparam int AM_BIT = 15;
	localparam int SM_HI = 14;
	localparam int SM_LO = 13;
	localparam int RN_HI = 12;
	localparam int RN_LO = 5;
	localparam int AS_HI = 12;
	localparam int AS_LO = 10;
	localparam int AI16_HI = 9;
	localparam int AI16_LO = 4;
	localparam int AI1_HI = 9;
	localparam int AI1_LO = 0;
	localparam int SR_HI = 4;
	localparam int SR_LO = 0;
	localparam int SR4_BIT = 4;
	localparam int CE_HI = 3;
	localparam int CE_LO = 0;
	// register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam logic [11:0] CNT_OFF = 12'h008;
	localparam logic [11:0] WORD_OFF = 12'h00C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int CTRL_EN_BIT = 0;
	localparam int STAT_RSV_BIT = 0;
	localparam int STAT_LAY_LO = 1;
	localparam int CNT_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// layouts, gray coded
	typedef enum logic [1:0] {
		LAYOUT_DIRECT_SCALAR = 2'h0,
		LAYOUT_DIRECT_FOUR = 2'h1,
		LAYOUT_INDIRECT_FOUR = 2'h3,
		LAYOUT_INDIRECT_SCALAR = 2'h2
	} layout_e;
endpackage

/* File: rtl/src1_field_extract.sv */
// combinational field extraction for one second-source doubleword
`timescale 1ns/1ps
module src1_field_extract (
	// doubleword and mode
	input wire logic [31:0] word_in,
	input wire logic indirect_in,
	input wire logic four_channel_in,
	input wire logic immediate_in,
	// fields
	output src1_decode_pkg::layout_e layout_out,
	output logic [3:0] vertical_stride_out,
	output logic [2:0] region_width_out,
	output logic [1:0] horizontal_stride_out,
	output logic [1:0] source_modifier_out,
	output logic [7:0] register_number_out,
	output logic [4:0] subregister_number_out,
	output logic addressing_mode_flag_out,
	output logic [2:0] address_reg_subnumber_out,
	output logic [9:0] address_immediate_out,
	output logic [3:0] channel_swizzle_out,
	output logic [3:0] channel_enable_mask_out,
	output logic reserved_bad_out
);
	always_comb begin
		layout_out = indirect_in ?
			(four_channel_in ? src1_decode_pkg::LAYOUT_INDIRECT_FOUR :
			src1_decode_pkg::LAYOUT_INDIRECT_SCALAR) :
			(four_channel_in ? src1_decode_pkg::LAYOUT_DIRECT_FOUR :
			src1_decode_pkg::LAYOUT_DIRECT_SCALAR);
		vertical_stride_out = 4'h0;
		region_width_out = 3'h0;
		horizontal_stride_out = 2'h0;
		source_modifier_out = 2'h0;
		register_number_out = 8'h00;
		subregister_number_out = 5'h00;
		addressing_mode_flag_out = 1'b0;
		address_reg_subnumber_out = 3'h0;
		address_immediate_out = 10'h000;
		channel_swizzle_out = 4'h0;
		channel_enable_mask_out = 4'h0;
		reserved_bad_out = 1'b0;
		// an immediate leaves every field but the layout at zero
		if (!immediate_in) begin
			vertical_stride_out = word_in[src1_decode_pkg::VS_HI:src1_decode_pkg::VS_LO];
			source_modifier_out = word_in[src1_decode_pkg::SM_HI:src1_decode_pkg::SM_LO];
			reserved_bad_out = |word_in[src1_decode_pkg::RSV_HI:src1_decode_pkg::RSV_LO];
			case (layout_out)
				src1_decode_pkg::LAYOUT_DIRECT_SCALAR: begin
					region_width_out = word_in[src1_decode_pkg::RW_HI:src1_decode_pkg::RW_LO];
					horizontal_stride_out = word_in[src1_decode_pkg::HS_HI:src1_decode_pkg::HS_LO];
					register_number_out = word_in[src1_decode_pkg::RN_HI:src1_decode_pkg::RN_LO];
					subregister_number_out = word_in[src1_decode_pkg::SR_HI:src1_decode_pkg::SR_LO];
					reserved_bad_out = reserved_bad_out | word_in[src1_decode_pkg::AM_BIT];
				end
				src1_decode_pkg::LAYOUT_DIRECT_FOUR: begin
					channel_swizzle_out = word_in[src1_decode_pkg::CS_HI:src1_decode_pkg::CS_LO];
					register_number_out = word_in[src1_decode_pkg::RN_HI:src1_decode_pkg::RN_LO];
					subregister_number_out = {word_in[src1_decode_pkg::SR4_BIT], 4'h0};
					channel_enable_mask_out = word_in[src1_decode_pkg::CE_HI:src1_decode_pkg::CE_LO];
					reserved_bad_out = reserved_bad_out | word_in[src1_decode_pkg::AM_BIT]
						| word_in[src1_decode_pkg::RSV20_BIT];
				end
				src1_decode_pkg::LAYOUT_INDIRECT_FOUR: begin
					// bit 20 only flagged, never decoded
					reserved_bad_out = reserved_bad_out | word_in[src1_decode_pkg::RSV20_BIT];
					channel_swizzle_out = word_in[src1_decode_pkg::CS_HI:src1_decode_pkg::CS_LO];
					addressing_mode_flag_out = word_in[src1_decode_pkg::AM_BIT];
					address_reg_subnumber_out = word_in[src1_decode_pkg::AS_HI:src1_decode_pkg::AS_LO];
					address_immediate_out = {word_in[src1_decode_pkg::AI16_HI:src1_decode_pkg::AI16_LO], 4'h0};
					channel_enable_mask_out = word_in[src1_decode_pkg::CE_HI:src1_decode_pkg::CE_LO];
				end
				src1_decode_pkg::LAYOUT_INDIRECT_SCALAR: begin
					region_width_out = word_in[src1_decode_pkg::RW_HI:src1_decode_pkg::RW_LO];
					horizontal_stride_out = word_in[src1_decode_pkg::HS_HI:src1_decode_pkg::HS_LO];
					addressing_mode_flag_out = word_in[src1_decode_pkg::AM_BIT];
					address_reg_subnumber_out = word_in[src1_decode_pkg::AS_HI:src1_decode_pkg::AS_LO];
					address_immediate_out = word_in[src1_decode_pkg::AI1_HI:src1_decode_pkg::AI1_LO];
				end
				default: begin
					reserved_bad_out = 1'b1;
				end
			endcase
		end
	end
endmodule // src1_field_extract

/* File: rtl/src1_operand_dword_decoder.sv */
// second-source doubleword decoder with its AXI4-Lite status registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module src1_operand_dword_decoder (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// from instruction fetch
	input wire logic dword_valid_in,
	input wire logic [31:0] src1_dword_in,
	input wire logic src0_is_imm_in,
	input wire logic src1_is_imm_in,
	input wire logic src1_indirect_in,
	input wire logic four_channel_in,
	// to operand fetch
	output logic fields_valid_out,
	output src1_decode_pkg::layout_e layout_out,
	output logic [3:0] vertical_stride_out,
	output logic [2:0] region_width_out,
	output logic [1:0] horizontal_stride_out,
	output logic [1:0] source_modifier_out,
	output logic [7:0] register_number_out,
	output logic [4:0] subregister_number_out,
	output logic addressing_mode_flag_out,
	output logic [2:0] address_reg_subnumber_out,
	output logic [9:0] address_immediate_out,
	output logic [3:0] channel_swizzle_out,
	output logic [3:0] channel_enable_mask_out,
	output logic immediate_valid_out,
	output logic [31:0] immediate_word_out,
	output logic reserved_violation_out,
	// axi4-lite write
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [11:0] axi_awaddr_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	output logic [1:0] axi_bresp_out,
	// axi4-lite read
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	input wire logic [11:0] axi_araddr_in,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic take;
	logic any_imm;
	src1_decode_pkg::layout_e ext_layout;
	logic [3:0] ext_vs;
	logic [2:0] ext_rw;
	logic [1:0] ext_hs;
	logic [1:0] ext_sm;
	logic [7:0] ext_rn;
	logic [4:0] ext_sr;
	logic ext_am;
	logic [2:0] ext_as;
	logic [9:0] ext_ai;
	logic [3:0] ext_cs;
	logic [3:0] ext_ce;
	logic ext_rsv;
	logic [31:0] ctrl_q;
	logic rsv_seen_q;
	logic [src1_decode_pkg::CNT_W-1:0] cnt_q;
	logic [31:0] last_word_q;
	logic aw_held_q;
	logic w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;

	// word-aligned decode; low address bits are ignored
	function automatic logic [11:0] word_addr(input logic [11:0] a);
		return {a[11:2], 2'h0};
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		logic [11:0] w;
		w = word_addr(a);
		return w == src1_decode_pkg::CTRL_OFF || w == src1_decode_pkg::STAT_OFF
			|| w == src1_decode_pkg::CNT_OFF || w == src1_decode_pkg::WORD_OFF;
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// reset release through two flops
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign any_imm = src0_is_imm_in | src1_is_imm_in;
	// software can pause decoding; words offered meanwhile are dropped
	assign take = dword_valid_in & ctrl_q[src1_decode_pkg::CTRL_EN_BIT];
	assign do_write = aw_held_q & w_held_q & ~axi_bvalid_out;

	src1_field_extract u_extract (
		.word_in(src1_dword_in),
		.indirect_in(src1_indirect_in),
		.four_channel_in(four_channel_in),
		.immediate_in(any_imm),
		.layout_out(ext_layout),
		.vertical_stride_out(ext_vs),
		.region_width_out(ext_rw),
		.horizontal_stride_out(ext_hs),
		.source_modifier_out(ext_sm),
		.register_number_out(ext_rn),
		.subregister_number_out(ext_sr),
		.addressing_mode_flag_out(ext_am),
		.address_reg_subnumber_out(ext_as),
		.address_immediate_out(ext_ai),
		.channel_swizzle_out(ext_cs),
		.channel_enable_mask_out(ext_ce),
		.reserved_bad_out(ext_rsv)
	);

	// decoded fields, held until the next accepted word
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			fields_valid_out <= 1'b0;
			layout_out <= src1_decode_pkg::LAYOUT_DIRECT_SCALAR;
			vertical_stride_out <= 4'h0;
			region_width_out <= 3'h0;
			horizontal_stride_out <= 2'h0;
			source_modifier_out <= 2'h0;
			register_number_out <= 8'h00;
			subregister_number_out <= 5'h00;
			addressing_mode_flag_out <= 1'b0;
			address_reg_subnumber_out <= 3'h0;
			address_immediate_out <= 10'h000;
			channel_swizzle_out <= 4'h0;
			channel_enable_mask_out <= 4'h0;
			immediate_valid_out <= 1'b0;
			immediate_word_out <= 32'h0000_0000;
			reserved_violation_out <= 1'b0;
		end else begin
			fields_valid_out <= take;
			if (take) begin
				layout_out <= ext_layout;
				vertical_stride_out <= ext_vs;
				region_width_out <= ext_rw;
				horizontal_stride_out <= ext_hs;
				source_modifier_out <= ext_sm;
				register_number_out <= ext_rn;
				subregister_number_out <= ext_sr;
				addressing_mode_flag_out <= ext_am;
				address_reg_subnumber_out <= ext_as;
				address_immediate_out <= ext_ai;
				channel_swizzle_out <= ext_cs;
				channel_enable_mask_out <= ext_ce;
				immediate_valid_out <= any_imm;
				immediate_word_out <= any_imm ? src1_dword_in : 32'h0000_0000;
				reserved_violation_out <= ext_rsv;
			end
		end
	end

	// decode statistics
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			last_word_q <= 32'h0000_0000;
		end else if (take) begin
			cnt_q <= cnt_q + 1'b1;
			last_word_q <= src1_dword_in;
		end
	end

	// sticky reserved-bit flag; a new hit beats a clear
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rsv_seen_q <= 1'b0;
		end else begin
			rsv_seen_q <= (take & ext_rsv) | (rsv_seen_q & ~(do_write
				& word_addr(awaddr_q) == src1_decode_pkg::STAT_OFF
				& wstrb_q[0] & wdata_q[src1_decode_pkg::STAT_RSV_BIT]));
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= src1_decode_pkg::CTRL_RST;
		end else if (do_write && word_addr(awaddr_q) == src1_decode_pkg::CTRL_OFF) begin
			ctrl_q <= merge_strb(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
		end
	end

	// write channels, taken in either order
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			axi_awready_out <= 1'b1;
			axi_wready_out <= 1'b1;
			axi_bvalid_out <= 1'b0;
			axi_bresp_out <= src1_decode_pkg::RESP_OKAY;
		end else begin
			if (axi_awvalid_in && axi_awready_out) begin
				aw_held_q <= 1'b1;
				awaddr_q <= axi_awaddr_in;
				axi_awready_out <= 1'b0;
			end
			if (axi_wvalid_in && axi_wready_out) begin
				w_held_q <= 1'b1;
				wdata_q <= axi_wdata_in;
				wstrb_q <= axi_wstrb_in;
				axi_wready_out <= 1'b0;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				axi_bvalid_out <= 1'b1;
				axi_bresp_out <= is_mapped(awaddr_q) ?
					src1_decode_pkg::RESP_OKAY : src1_decode_pkg::RESP_DECERR;
			end
			if (axi_bvalid_out && axi_bready_in) begin
				axi_bvalid_out <= 1'b0;
				axi_awready_out <= 1'b1;
				axi_wready_out <= 1'b1;
			end
		end
	end

	// read channel, answer one edge after the address is taken
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			axi_arready_out <= 1'b1;
			axi_rvalid_out <= 1'b0;
			axi_rdata_out <= 32'h0000_0000;
			axi_rresp_out <= src1_decode_pkg::RESP_OKAY;
		end else if (axi_arvalid_in && axi_arready_out) begin
			axi_arready_out <= 1'b0;
			axi_rvalid_out <= 1'b1;
			axi_rresp_out <= is_mapped(axi_araddr_in) ?
				src1_decode_pkg::RESP_OKAY : src1_decode_pkg::RESP_DECERR;
			case (word_addr(axi_araddr_in))
				src1_decode_pkg::CTRL_OFF: axi_rdata_out <= ctrl_q;
				src1_decode_pkg::STAT_OFF: axi_rdata_out <= {29'h0000_0000,
					layout_out, rsv_seen_q};
				src1_decode_pkg::CNT_OFF: axi_rdata_out <= {16'h0000, cnt_q};
				src1_decode_pkg::WORD_OFF: axi_rdata_out <= last_word_q;
				default: axi_rdata_out <= 32'h0000_0000;
			endcase
		end else if (axi_rvalid_out && axi_rready_in) begin
			axi_rvalid_out <= 1'b0;
			axi_arready_out <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n);

	logic reg_only;
	logic d_scalar;
	logic i_four;
	logic i_scalar;
	assign reg_only = take & ~any_imm;
	assign d_scalar = reg_only & ~src1_indirect_in & ~four_channel_in;
	assign i_four = reg_only & src1_indirect_in & four_channel_in;
	assign i_scalar = reg_only & src1_indirect_in & ~four_channel_in;

	word_kept_a: assert property (take |=> last_word_q == $past(src1_dword_in))
		else $error("captured word wrong");
	d_region_a: assert property (d_scalar |=> region_width_out == last_word_q[20:18]
		&& horizontal_stride_out == last_word_q[17:16])
		else $error("direct region fields wrong");
	d_register_number_a: assert property (d_scalar |=> register_number_out == last_word_q[12:5])
		else $error("register number wrong");
	d_subreg_a: assert property (d_scalar |=> subregister_number_out == last_word_q[4:0])
		else $error("subregister number wrong");
	vert_stride_a: assert property (reg_only |=> vertical_stride_out == last_word_q[24:21])
		else $error("vertical stride wrong");
	src_mod_a: assert property (reg_only |=> source_modifier_out == last_word_q[14:13])
		else $error("source modifier wrong");
	i4_reserved_a: assert property (i_four |=> region_width_out == 3'h0
		&& reserved_violation_out == (|last_word_q[31:25] | last_word_q[20]))
		else $error("reserved bits leaked");
	i4_swizzle_a: assert property (i_four |=> channel_swizzle_out == last_word_q[19:16])
		else $error("swizzle wrong");
	i4_addr_imm_a: assert property (i_four |=> address_immediate_out
		== {last_word_q[9:4], 4'h0})
		else $error("aligned address immediate wrong");
	i4_chan_en_a: assert property (i_four |=> channel_enable_mask_out == last_word_q[3:0])
		else $error("channel enable wrong");
	ind_mode_a: assert property ((i_four || i_scalar) |=>
		addressing_mode_flag_out == last_word_q[15])
		else $error("addressing mode flag wrong");
	ind_subnum_a: assert property ((i_four || i_scalar) |=>
		address_reg_subnumber_out == last_word_q[12:10])
		else $error("address register subnumber wrong");
	i1_region_a: assert property (i_scalar |=> region_width_out == last_word_q[20:18]
		&& horizontal_stride_out == last_word_q[17:16])
		else $error("indirect region fields wrong");
	i1_addr_imm_a: assert property (i_scalar |=> address_immediate_out == last_word_q[9:0])
		else $error("byte address immediate wrong");
	imm_fields_a: assert property (take && any_imm |=> register_number_out == 8'h00
		&& vertical_stride_out == 4'h0 && channel_enable_mask_out == 4'h0)
		else $error("fields not cleared for immediate");
	imm_word_a: assert property (take && any_imm |=> immediate_valid_out
		&& immediate_word_out == last_word_q)
		else $error("immediate word wrong");
	layout_sel_a: assert property (take |=> layout_out == {$past(src1_indirect_in),
		$past(four_channel_in)})
		else $error("layout selection wrong");
	read_answer_a: assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out)
		else $error("read answer late");

	ind_four_c: cover property (i_four ##1 fields_valid_out);
	ind_scalar_c: cover property (i_scalar ##1 fields_valid_out);
	immediate_c: cover property (take && any_imm ##1 immediate_valid_out);
	axi_write_c: cover property (do_write ##1 axi_bvalid_out);
endmodule // src1_operand_dword_decoder

/* File: tb/fetch_model.sv */
// fetch-side model: offers one doubleword with its mode bits
`timescale 1ns/1ps
module fetch_model (
	// clock
	input wire logic clk_in,
	// to decoder
	output logic valid_out,
	output logic [31:0] word_out,
	output logic src0_imm_out,
	output logic src1_imm_out,
	output logic indirect_out,
	output logic four_out
);
	initial begin
		valid_out = 1'b0;
		word_out = 32'h0000_0000;
		{src0_imm_out, src1_imm_out, indirect_out, four_out} = 4'h0;
	end
	// mode is {src0 imm, src1 imm, indirect, four-channel}
	// bad leaves reserved bits as given, to provoke the decoder
	task automatic send(input logic [31:0] w, input logic [3:0] mode,
		input logic bad);
		@(posedge clk_in);
		valid_out <= 1'b1;
		word_out <= (bad || mode[1:0] != 2'h3) ? w : (w & 32'h01EF_FFFF);
		{src0_imm_out, src1_imm_out, indirect_out, four_out} <= mode;
		@(posedge clk_in);
		valid_out <= 1'b0;
		// released word changes, so stale data cannot pass for held fields
		word_out <= ~word_out;
	endtask
endmodule // fetch_model

/* File: tb/tb.sv */
// self-checking bench for the second-source doubleword decoder
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic dv, s0i, s1i, ind, four, fv, imv, rsv, amf;
	logic [31:0] dw, imw, rdata;
	src1_decode_pkg::layout_e lay;
	logic [3:0] vs, swz, cem;
	logic [2:0] rw, asub;
	logic [1:0] hs, sm, bresp, rresp;
	logic [7:0] rn;
	logic [4:0] sr;
	logic [9:0] aimm;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wr, bv, arr, rv;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0000_0000;
	int err_total = 0;
	int checked = 0;
	always #2.5 clk = ~clk;
	fetch_model fetch_model_inst (.clk_in(clk), .valid_out(dv), .word_out(dw),
		.src0_imm_out(s0i), .src1_imm_out(s1i), .indirect_out(ind),
		.four_out(four));
	src1_operand_dword_decoder src1_operand_dword_decoder_inst (
		.clk_sys_in(clk), .rst_n_in(rst_n), .dword_valid_in(dv),
		.src1_dword_in(dw), .src0_is_imm_in(s0i), .src1_is_imm_in(s1i),
		.src1_indirect_in(ind), .four_channel_in(four),
		.fields_valid_out(fv), .layout_out(lay), .vertical_stride_out(vs),
		.region_width_out(rw), .horizontal_stride_out(hs),
		.source_modifier_out(sm), .register_number_out(rn),
		.subregister_number_out(sr), .addressing_mode_flag_out(amf),
		.address_reg_subnumber_out(asub), .address_immediate_out(aimm),
		.channel_swizzle_out(swz), .channel_enable_mask_out(cem),
		.immediate_valid_out(imv), .immediate_word_out(imw),
		.reserved_violation_out(rsv),
		.axi_awvalid_in(awv), .axi_awready_out(awr), .axi_awaddr_in(awa),
		.axi_wvalid_in(wv), .axi_wready_out(wr), .axi_wdata_in(wd),
		.axi_wstrb_in(4'hf), .axi_bvalid_out(bv), .axi_bready_in(br),
		.axi_bresp_out(bresp), .axi_arvalid_in(arv), .axi_arready_out(arr),
		.axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rr),
		.axi_rdata_out(rdata), .axi_rresp_out(rresp));
	task automatic results;
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic hang;
		err_total++;
		results();
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic aw_p;
		logic w_p;
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		br <= 1'b1;
		// own pending flags: the nonblocking raise is not visible yet
		aw_p = 1'b1;
		w_p = 1'b1;
		for (n = 0; n < 40 && (aw_p || w_p); n++) begin
			@(posedge clk);
			if (aw_p && awr === 1'b1) begin
				awv <= 1'b0;
				aw_p = 1'b0;
			end
			if (w_p && wr === 1'b1) begin
				wv <= 1'b0;
				w_p = 1'b0;
			end
		end
		if (n == 40) hang();
		for (n = 0; n < 40 && bv !== 1'b1; n++) @(posedge clk);
		if (n == 40) hang();
		br <= 1'b0;
		`CHK(bresp, er)
	endtask
	task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		logic ar_p;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		ar_p = 1'b1;
		for (n = 0; n < 40 && ar_p; n++) begin
			@(posedge clk);
			if (arr === 1'b1) begin
				arv <= 1'b0;
				ar_p = 1'b0;
			end
		end
		if (n == 40) hang();
		for (n = 0; n < 40 && rv !== 1'b1; n++) @(posedge clk);
		if (n == 40) hang();
		rr <= 1'b0;
		`CHK(rdata, ed)
		`CHK(rresp, er)
	endtask
	// one word through the model, then exactly one pulse one edge later
	task automatic decode(input logic [31:0] w, input logic [3:0] mode,
		input logic bad);
		int n;
		fetch_model_inst.send(w, mode, bad);
		for (n = 0; n < 4 && fv !== 1'b1; n++) @(posedge clk);
		if (n == 4) hang();
		`CHK(n, 1)
		#1;
		`CHK(fv, 1'b0)
	endtask
	task automatic direct_scalar;
		logic [31:0] w = 32'h01AB_5ABC;
		decode(w, 4'h0, 1'b0);
		`CHK(lay, src1_decode_pkg::LAYOUT_DIRECT_SCALAR)
		`CHK(vs, w[24:21])
		`CHK(rw, w[20:18])
		`CHK(hs, w[17:16])
		`CHK(sm, w[14:13])
		`CHK(rn, w[12:5])
		`CHK(sr, w[4:0])
		`CHK(amf, 1'b0)
		`CHK(rsv, 1'b0)
		`CHK(imv, 1'b0)
		`CHK(imw, 32'h0000_0000)
	endtask
	// reserved bits set except bit 25: they must not leak into any field
	task automatic indirect_four;
		logic [31:0] w = 32'hFDB6_9A5D;
		decode(w, 4'h3, 1'b1);
		`CHK(lay, src1_decode_pkg::LAYOUT_INDIRECT_FOUR)
		`CHK(vs, w[24:21])
		`CHK(swz, w[19:16])
		`CHK(amf, w[15])
		`CHK(sm, w[14:13])
		`CHK(asub, w[12:10])
		`CHK(aimm, {w[9:4], 4'h0})
		`CHK(cem, w[3:0])
		`CHK(rw, 3'h0)
		`CHK(rsv, 1'b1)
	endtask
	task automatic indirect_scalar;
		logic [31:0] w = 32'h00E7_B5A5;
		decode(w, 4'h2, 1'b0);
		`CHK(lay, src1_decode_pkg::LAYOUT_INDIRECT_SCALAR)
		`CHK(vs, w[24:21])
		`CHK(rw, w[20:18])
		`CHK(hs, w[17:16])
		`CHK(amf, w[15])
		`CHK(asub, w[12:10])
		`CHK(aimm, w[9:0])
	endtask
	task automatic direct_four;
		logic [31:0] w = 32'h0053_3FF3;
		decode(w, 4'h1, 1'b0);
		`CHK(lay, src1_decode_pkg::LAYOUT_DIRECT_FOUR)
		`CHK(sm, w[14:13])
		`CHK(rn, w[12:5])
		`CHK(sr, {w[4], 4'h0})
		`CHK(cem, w[3:0])
	endtask
	// immediate in each source position, with indirect four-channel mode bits set for the src0 one
	task automatic immediate;
		logic [31:0] w;
		for (int i = 0; i < 2; i++) begin
			w = i ? 32'h8765_4321 : 32'hDEAD_BEEF;
			decode(w, i ? 4'h4 : 4'hB, 1'b1);
			`CHK(imw, w)
			`CHK(imv, 1'b1)
			`CHK(vs, 4'h0)
			`CHK(rn, 8'h00)
			`CHK(aimm, 10'h000)
			`CHK(cem, 4'h0)
		end
	endtask
	// sticky reserved hit from both four-channel words, then cleared by 1
	task automatic status_flag;
		axi_rd(src1_decode_pkg::STAT_OFF, 32'h0000_0001,
			src1_decode_pkg::RESP_OKAY);
		axi_wr(src1_decode_pkg::STAT_OFF, 32'h0000_0001,
			src1_decode_pkg::RESP_OKAY);
		axi_rd(src1_decode_pkg::STAT_OFF, 32'h0000_0000,
			src1_decode_pkg::RESP_OKAY);
	endtask
	// decode switched off: word dropped, count frozen; unmapped place
	task automatic disabled;
		axi_wr(src1_decode_pkg::CTRL_OFF, 32'h0000_0000,
			src1_decode_pkg::RESP_OKAY);
		fetch_model_inst.send(32'h0123_4567, 4'h0, 1'b0);
		repeat (4) begin
			@(posedge clk);
			`CHK(fv, 1'b0)
		end
		axi_rd(src1_decode_pkg::CNT_OFF, 32'h0000_0006,
			src1_decode_pkg::RESP_OKAY);
		axi_wr(12'h010, 32'h0000_0001, src1_decode_pkg::RESP_DECERR);
		axi_rd(12'h010, 32'h0000_0000, src1_decode_pkg::RESP_DECERR);
		axi_wr(src1_decode_pkg::CTRL_OFF, 32'h0000_0001,
			src1_decode_pkg::RESP_OKAY);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		axi_rd(src1_decode_pkg::CTRL_OFF, src1_decode_pkg::CTRL_RST,
			src1_decode_pkg::RESP_OKAY);
		direct_scalar();
		indirect_four();
		indirect_scalar();
		direct_four();
		immediate();
		axi_rd(src1_decode_pkg::WORD_OFF, 32'h8765_4321,
			src1_decode_pkg::RESP_OKAY);
		status_flag();
		disabled();
		results();
	end
endmodule // tb
